//--- common/sac_pkg.sv
// shared constants and types for the converter trigger and channel control
//
// Behaviour
// - results are always eight bits; no ten or twelve bit modes exist
// - conversion clock is bus clock, bus clock halved, or local clock
// - the alternate conversion clock is absent; its code falls back to bus
// - with hardware triggering on, each wake-up counter overflow outside a conversion starts one
// - wake-up counter runs freely from external or 1 kHz source at set rate
// - hardware triggers start conversions in run mode and in stop mode
// - codes 0 to 11 pick pins; 29 picks high, 30 low reference
// - each pin channel has its own enable bit, pins 0..11 to bits 0..11
// - reserved codes 12 to 28 still convert, result value is undefined
// - stop mode conversions need both low-voltage enable bits set
// - only two pin enable registers exist, no third one
// - single or continuous; single returns idle, done flag and interrupt
// - compare against programmable value, less-than or at-least, flags
// - control write aborts, and with software triggering restarts unless channel code is all ones
// - all ones channel turns converter off, no extra continuous conversion
// - trigger select picks software write or hardware trigger input
// - done flag set per completion or true compare; write or read clears
package sac_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned INT_WAKE_HZ     = 1000;
    localparam int unsigned INT_WAKE_CYCLES = CLK_HZ / INT_WAKE_HZ;
    localparam int unsigned WAKE_DIV_W      = 18;
    localparam int unsigned WAKE_CNT_W      = 10;
    localparam logic [9:0]  WAKE_CNT_FULL   = 10'h3ff;
    localparam logic [2:0]  RATE_OFF        = 3'h0;
    localparam logic [2:0]  RATE_MAX        = 3'h7;

    // ------------------------------------------------------------------
    // conversion clock select codes
    // ------------------------------------------------------------------
    localparam logic [1:0] CK_BUS       = 2'h0;
    localparam logic [1:0] CK_BUS_DIV2  = 2'h1;
    localparam logic [1:0] CK_ALT       = 2'h2;
    localparam logic [1:0] CK_LOCAL     = 2'h3;
    localparam logic [1:0] LOCAL_DIV_LAST = 2'h3;

    // ------------------------------------------------------------------
    // channel codes and widths
    // ------------------------------------------------------------------
    localparam int unsigned NUM_PINS    = 12;
    localparam int unsigned RES_BITS    = 8;
    localparam logic [4:0] CH_REF_HIGH  = 5'h1d;
    localparam logic [4:0] CH_REF_LOW   = 5'h1e;
    localparam logic [4:0] CH_DISABLED  = 5'h1f;
    localparam logic [7:0] SAR_MSB      = 8'h80;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } sac_state_type;

endpackage

//--- core/sac_adc_ctrl.sv
// channel decode, conversion clocking, triggering and done-flag control
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl
    import sac_pkg::*;
#(
    parameter int unsigned INT_CYCLES = INT_WAKE_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // first status-control register contents and write strobe
    input  wire logic        sc1_write,
    input  wire logic [4:0]  channel_select,
    input  wire logic        cont_enable,
    input  wire logic        int_enable,
    // second status-control and compare settings
    input  wire logic        trigger_type_select,
    input  wire logic        compare_function_enable,
    input  wire logic        compare_ge_mode,
    input  wire logic [7:0]  compare_value,
    // configuration
    input  wire logic [1:0]  clock_select,
    input  wire logic [7:0]  pin_analog_enable_reg_1,
    input  wire logic [3:0]  pin_analog_enable_reg_2,
    input  wire logic        result_low_read,
    // power management
    input  wire logic        stop_mode,
    input  wire logic        lowvolt_detect_enable,
    input  wire logic        lowvolt_detect_stop_enable,
    // periodic wake-up counter setup
    input  wire logic        wake_src_external,
    input  wire logic        external_reference_clock,
    input  wire logic [2:0]  periodic_rate_select,
    // analog core
    input  wire logic        sar_cmp_in,
    output logic [7:0]       sar_trial,
    output logic             sar_power,
    output logic [11:0]      pin_select,
    output logic             ref_high_select,
    output logic             ref_low_select,
    // status
    output logic             conversion_done_flag,
    output logic             conv_irq,
    output logic             conv_active,
    output logic [7:0]       result
);

    sac_state_type         state_q;
    logic [RES_BITS-1:0]   trial_q;
    logic [RES_BITS-1:0]   bit_q;
    logic [RES_BITS-1:0]   result_q;
    logic [NUM_PINS-1:0]   pin_sel_q;
    logic                  ref_high_q;
    logic                  ref_low_q;
    logic                  power_q;
    logic                  done_q;
    logic                  irq_q;
    logic [1:0]            div_q;
    logic                  hw_conversion_trigger;

    // ------------------------------------------------------------------
    // hardware trigger source
    // ------------------------------------------------------------------
    sac_wakeup_ctr #(
        .INT_CYCLES (INT_CYCLES)
    ) u_periodic_wakeup_counter (
        .clk                      (clk),
        .rst                      (rst),
        .wake_src_external        (wake_src_external),
        .external_reference_clock (external_reference_clock),
        .periodic_rate_select     (periodic_rate_select),
        .overflow                 (hw_conversion_trigger)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire [NUM_PINS-1:0] pin_enable =
        {pin_analog_enable_reg_2, pin_analog_enable_reg_1};
    wire [NUM_PINS-1:0] pin_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            assign pin_hit[gi] = (channel_select == 5'(gi))
                && pin_enable[gi];
        end
    endgenerate

    wire ch_off     = channel_select == CH_DISABLED;
    wire ch_ref_hi  = channel_select == CH_REF_HIGH;
    wire ch_ref_lo  = channel_select == CH_REF_LOW;
    wire allowed    = !stop_mode
        || (lowvolt_detect_enable && lowvolt_detect_stop_enable);
    wire converting = state_q == ST_CONV;

    // alternate clock is not built, so its code runs at bus rate
    wire conv_tick =
        (clock_select == CK_BUS_DIV2) ? div_q[0] :
        (clock_select == CK_LOCAL)    ? (div_q == LOCAL_DIV_LAST) :
                                        1'b1;

    wire abort     = sc1_write || !allowed;
    wire last_bit  = bit_q[0];
    wire [RES_BITS-1:0] decided = sar_cmp_in ? trial_q : trial_q ^ bit_q;
    wire done_evt  = converting && conv_tick && last_bit && !abort;
    wire cmp_true  = compare_ge_mode ? (decided >= compare_value)
                                     : (decided <  compare_value);
    wire set_flag  = done_evt
        && (!compare_function_enable || cmp_true);
    wire clr_flag  = sc1_write || result_low_read;

    wire sw_start  = sc1_write && !ch_off && !trigger_type_select
        && allowed;
    wire hw_start  = hw_conversion_trigger && trigger_type_select
        && !ch_off && allowed && !sc1_write && !converting;
    wire restart   = done_evt && cont_enable && !ch_off && allowed;
    wire start     = sw_start || hw_start || restart;
    wire go_idle   = abort || done_evt || ch_off;

    // ------------------------------------------------------------------
    // conversion clock divider
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // approximation sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            trial_q <= RESULT_RESET;
            bit_q   <= RESULT_RESET;
        end else if (start) begin
            state_q <= ST_CONV;
            trial_q <= SAR_MSB;
            bit_q   <= SAR_MSB;
        end else if (go_idle) begin
            state_q <= ST_IDLE;
            bit_q   <= RESULT_RESET;
        end else if (converting && conv_tick) begin
            trial_q <= decided | (bit_q >> 1);
            bit_q   <= bit_q >> 1;
        end
    end

    // reserved codes light no mux leg, so their result is meaningless
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sel_q  <= '0;
            ref_high_q <= 1'b0;
            ref_low_q  <= 1'b0;
            power_q    <= 1'b0;
        end else if (start) begin
            pin_sel_q  <= pin_hit;
            ref_high_q <= ch_ref_hi;
            ref_low_q  <= ch_ref_lo;
            power_q    <= 1'b1;
        end else if (go_idle) begin
            pin_sel_q  <= '0;
            ref_high_q <= 1'b0;
            ref_low_q  <= 1'b0;
            power_q    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // result and flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            result_q <= RESULT_RESET;
        end else if (set_flag) begin
            result_q <= decided;
        end
    end

    // a completion landing on a clearing access still raises the flag
    always_ff @(posedge clk) begin
        if (rst) begin
            done_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            done_q <= set_flag | (done_q & ~clr_flag);
            irq_q  <= (set_flag | (done_q & ~clr_flag))
                & int_enable;
        end
    end

    assign sar_trial            = trial_q;
    assign sar_power            = power_q;
    assign pin_select           = pin_sel_q;
    assign ref_high_select      = ref_high_q;
    assign ref_low_select       = ref_low_q;
    assign conversion_done_flag = done_q;
    assign conv_irq             = irq_q;
    assign conv_active          = converting;
    assign result               = result_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_DONE_SETS: assert property (
        set_flag |=> done_q)
        else $error("done flag not set after completion");

    AST_ACCESS_CLEARS: assert property (
        clr_flag && !set_flag |=> !done_q)
        else $error("done flag survived write or result read");

    AST_CMP_FALSE_NO_FLAG: assert property (
        done_evt && compare_function_enable && !cmp_true && !done_q
        && !clr_flag |=> !done_q)
        else $error("done flag set on false compare");

    AST_OFF_CODE_IDLE: assert property (
        sc1_write && ch_off |=> !converting && !power_q)
        else $error("all-ones channel did not shut converter off");

    AST_SW_START: assert property (
        sw_start |=> converting && bit_q == SAR_MSB && power_q)
        else $error("control write did not start conversion");

    AST_HW_START: assert property (
        hw_conversion_trigger && trigger_type_select && !converting
        && !ch_off && allowed && !sc1_write |=> converting)
        else $error("wake-up overflow did not start conversion");

    AST_SW_IGNORED_IN_HW: assert property (
        sc1_write && trigger_type_select |=> !converting)
        else $error("write started conversion in hardware trigger mode");

    AST_SINGLE_IDLE: assert property (
        done_evt && !cont_enable |=> !converting ##0 !power_q)
        else $error("single conversion did not return to idle");

    AST_STOP_BLOCK: assert property (
        stop_mode && !(lowvolt_detect_enable && lowvolt_detect_stop_enable)
        |=> !converting)
        else $error("conversion ran in stop without low-voltage enables");

    AST_REF_HIGH: assert property (
        start && ch_ref_hi |=> ref_high_q && !ref_low_q && pin_sel_q == '0)
        else $error("high reference not selected");

    AST_PIN_ONEHOT: assert property (
        converting |-> $onehot0(pin_sel_q))
        else $error("more than one pin selected");

    AST_BUS_LENGTH: assert property (
        sw_start && clock_select == CK_BUS ##1
        (clock_select == CK_BUS && !abort && !cont_enable) [*8]
        |=> !converting)
        else $error("bus-clock conversion did not take eight cycles");

    COV_SINGLE: cover property (done_evt && !cont_enable);
    COV_CONT: cover property (restart);
    COV_HW: cover property (hw_start);
    COV_CMP_MATCH: cover property (set_flag && compare_function_enable);

endmodule
`default_nettype wire

//--- core/sac_wakeup_ctr.sv
// free-running periodic wake-up counter that issues the hardware trigger
`timescale 1ns/1ps
`default_nettype none
module sac_wakeup_ctr
    import sac_pkg::*;
#(
    parameter int unsigned INT_CYCLES = INT_WAKE_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // source and rate
    input  wire logic       wake_src_external,
    input  wire logic       external_reference_clock,
    input  wire logic [2:0] periodic_rate_select,
    // trigger out
    output logic            overflow
);

    logic                  ext_meta_q;
    logic                  ext_sync_q;
    logic                  ext_prev_q;
    logic [WAKE_DIV_W-1:0] int_cnt_q;
    logic [WAKE_CNT_W-1:0] wcnt_q;
    logic                  ovf_q;

    wire ext_tick = ext_sync_q & ~ext_prev_q;
    wire int_tick = int_cnt_q == WAKE_DIV_W'(INT_CYCLES - 1);
    wire src_tick = wake_src_external ? ext_tick : int_tick;
    wire [WAKE_CNT_W-1:0] rate_mask =
        WAKE_CNT_FULL >> (RATE_MAX - periodic_rate_select);
    wire at_top = (wcnt_q & rate_mask) == rate_mask;
    wire running = periodic_rate_select != RATE_OFF;

    // reference clock is slow and foreign: two flops before edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_meta_q <= external_reference_clock;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || int_tick) begin
            int_cnt_q <= '0;
        end else begin
            int_cnt_q <= int_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !running) begin
            wcnt_q <= '0;
        end else if (src_tick) begin
            wcnt_q <= at_top ? '0 : wcnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= src_tick && running && at_top;
        end
    end

    assign overflow = ovf_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_OVF_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
        ovf_q |=> !ovf_q)
        else $error("wake-up overflow lasted more than one cycle");

    AST_OFF_NO_OVF: assert property (@(posedge clk) disable iff (rst)
        !running [*2] |=> !ovf_q)
        else $error("wake-up overflow while counter is off");

    COV_OVF: cover property (@(posedge clk) disable iff (rst) ovf_q);

endmodule
`default_nettype wire

//--- tb/sac_analog_model.sv
// behavioural analog front end: pin levels, references and comparator
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
    // clock
    input  wire logic        clk,
    // mux leg and trial code from the converter
    input  wire logic [7:0]  sar_trial,
    input  wire logic        sar_power,
    input  wire logic [11:0] pin_select,
    input  wire logic        ref_high_select,
    input  wire logic        ref_low_select,
    // comparator decision
    output logic             sar_cmp_in
);
    logic       wobble_q = 1'b0;
    logic [7:0] level;
    logic       leg_on;

    always_ff @(posedge clk) begin
        wobble_q <= ~wobble_q;
    end

    // pin n sits at n*16+7 so every pin converts to a code of its own
    always_comb begin
        level = 8'h00;
        for (int n = 0; n < 12; n++) begin
            if (pin_select[n]) begin
                level = 8'(n * 16 + 7);
            end
        end
        if (ref_high_select) begin
            level = 8'hff;
        end
    end

    assign leg_on = (|pin_select) | ref_high_select | ref_low_select;
    // an open or unpowered input reads as noise, never as a steady level
    assign sar_cmp_in = (sar_power && leg_on) ? (level >= sar_trial)
                                              : wobble_q;
endmodule
`default_nettype wire

//--- tb/test_sac_adc_ctrl.sv
// self-checking bench for the converter trigger and channel control
`timescale 1ns/1ps
`default_nettype none
module test_sac_adc_ctrl;
    import sac_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    // short wake-up prescale makes each counter step 4 cycles, so rate 1 triggers every 64 cycles
    localparam int unsigned INT_SIM = 4;
    logic        clk = 1'b0;
    logic        rst, sc1_write, cont_enable, int_enable;
    logic [4:0]  channel_select;
    logic        trigger_type_select, compare_function_enable;
    logic        compare_ge_mode, result_low_read, stop_mode;
    logic [7:0]  compare_value, pin_analog_enable_reg_1, sar_trial, result;
    logic [1:0]  clock_select;
    logic [3:0]  pin_analog_enable_reg_2;
    logic        lowvolt_detect_enable, lowvolt_detect_stop_enable;
    logic        wake_src_external, external_reference_clock;
    logic [2:0]  periodic_rate_select;
    logic        sar_cmp_in, sar_power, ref_high_select, ref_low_select;
    logic [11:0] pin_select;
    logic        conversion_done_flag, conv_irq, conv_active;
    logic [2:0]  ext_div_q = 3'h0;
    int          n_fail = 0;
    int          n_tests = 0;

    always #2.5 clk = ~clk;
    // the reference clock runs free at an eighth of clk
    always @(negedge clk) begin
        ext_div_q <= ext_div_q + 3'h1;
    end
    assign external_reference_clock = ext_div_q[2];

    sac_adc_ctrl #(.INT_CYCLES(INT_SIM)) sac_adc_ctrl_i (
        .clk, .rst, .sc1_write, .channel_select, .cont_enable, .int_enable,
        .trigger_type_select, .compare_function_enable, .compare_ge_mode,
        .compare_value, .clock_select, .pin_analog_enable_reg_1,
        .pin_analog_enable_reg_2, .result_low_read, .stop_mode,
        .lowvolt_detect_enable, .lowvolt_detect_stop_enable,
        .wake_src_external, .external_reference_clock,
        .periodic_rate_select, .sar_cmp_in, .sar_trial, .sar_power,
        .pin_select, .ref_high_select, .ref_low_select,
        .conversion_done_flag, .conv_irq, .conv_active, .result);

    sac_analog_model sac_analog_model_i (
        .clk, .sar_trial, .sar_power, .pin_select, .ref_high_select,
        .ref_low_select, .sar_cmp_in);

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // called at a falling edge; strobe lasts exactly one rising edge
    task automatic sw_write(input logic [4:0] ch);
        channel_select = ch;
        sc1_write = 1'b1;
        tick(1);
        sc1_write = 1'b0;
    endtask

    task automatic wait_done;
        for (int i = 0; i < 100 && conversion_done_flag !== 1'b1; i++) begin
            tick(1);
        end
    endtask

    task automatic read_clear;
        result_low_read = 1'b1;
        tick(1);
        result_low_read = 1'b0;
        tick(1);
        check(conversion_done_flag, 1'b0);
    endtask

    task automatic starts(input int cycles, output int n);
        logic prev;
        n = 0;
        prev = conv_active;
        repeat (cycles) begin
            tick(1);
            if (conv_active === 1'b1 && prev !== 1'b1) n++;
            prev = conv_active;
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic convert(input logic [4:0] ch, input logic [11:0] leg,
                           input logic [1:0] refs, input logic [7:0] exp);
        sw_write(ch);
        check(sar_trial, SAR_MSB);
        tick(1);
        check(pin_select, leg);
        check({ref_high_select, ref_low_select}, refs);
        check(sar_power, 1'b1);
        wait_done();
        check(conversion_done_flag, 1'b1);
        check(conv_irq, int_enable);
        check(conv_active, 1'b0);
        check(result, exp);
        tick(1);
        check(sar_power, 1'b0);
        read_clear();
    endtask

    task automatic t_no_leg(input logic [4:0] ch);
        sw_write(ch);
        tick(1);
        check({pin_select, ref_high_select, ref_low_select}, 14'h0);
        check(conv_active, 1'b1);
        wait_done();
        check(conversion_done_flag, 1'b1);
        read_clear();
    endtask

    task automatic t_clock;
        int lo [4] = '{8, 15, 8, 29};
        int hi [4] = '{8, 16, 8, 32};
        int len;
        for (int c = 0; c < 4; c++) begin
            clock_select = 2'(c);
            sw_write(5'h1);
            len = 0;
            for (int i = 0; i < 100 && conv_active === 1'b1; i++) begin
                len++;
                tick(1);
            end
            check(len >= lo[c] && len <= hi[c], 1'b1);
            check(result, 8'h17);
            read_clear();
        end
        clock_select = CK_BUS;
    endtask

    task automatic no_flag(input logic [4:0] ch, input logic [7:0] kept);
        sw_write(ch);
        tick(40);
        check(conversion_done_flag, 1'b0);
        check(result, kept);
    endtask

    task automatic t_compare;
        compare_function_enable = 1'b1;
        int_enable = 1'b1;
        compare_ge_mode = 1'b1;
        compare_value = 8'h37;
        convert(5'h3, 12'h008, 2'b00, 8'h37);
        compare_value = 8'h38;
        no_flag(5'h3, 8'h37);
        compare_ge_mode = 1'b0;
        compare_value = 8'h57;
        no_flag(5'h5, 8'h37);
        compare_value = 8'h58;
        convert(5'h5, 12'h020, 2'b00, 8'h57);
        compare_function_enable = 1'b0;
        int_enable = 1'b0;
    endtask

    task automatic t_cont;
        cont_enable = 1'b1;
        sw_write(5'h2);
        wait_done();
        check(result, 8'h27);
        check(conv_active, 1'b1);
        read_clear();
        wait_done();
        check(conversion_done_flag, 1'b1);
        sw_write(CH_DISABLED);
        check({conv_active, sar_power, conversion_done_flag}, 3'h0);
        tick(40);
        check({conv_active, conversion_done_flag}, 2'h0);
        cont_enable = 1'b0;
    endtask

    task automatic t_hw;
        int n;
        trigger_type_select = 1'b1;
        sw_write(5'h0);
        check(conv_active, 1'b0);
        tick(80);
        starts(256, n);
        check(n, 0);
        periodic_rate_select = 3'h1;
        tick(150);
        starts(256, n);
        check(n, 4);
        wake_src_external = 1'b1;
        tick(300);
        starts(256, n);
        check(n, 2);
        wake_src_external = 1'b0;
        stop_mode = 1'b1;
        tick(150);
        starts(256, n);
        check(n, 0);
        lowvolt_detect_enable = 1'b1;
        lowvolt_detect_stop_enable = 1'b1;
        tick(80);
        starts(256, n);
        check(n, 4);
        trigger_type_select = 1'b0;
        lowvolt_detect_stop_enable = 1'b0;
        sw_write(5'h0);
        check(conv_active, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        {rst, sc1_write, cont_enable, int_enable} = 4'h8;
        {trigger_type_select, compare_function_enable} = 2'h0;
        {compare_ge_mode, result_low_read, stop_mode} = 3'h0;
        {lowvolt_detect_enable, lowvolt_detect_stop_enable} = 2'h0;
        channel_select = CH_DISABLED;
        compare_value = 8'h00;
        clock_select = CK_BUS;
        pin_analog_enable_reg_1 = 8'hff;
        pin_analog_enable_reg_2 = 4'hf;
        wake_src_external = 1'b0;
        periodic_rate_select = RATE_OFF;
        tick(2);
        rst = 1'b0;
        check({sar_trial, sar_power, pin_select, conv_active}, 22'h0);
        check({conversion_done_flag, conv_irq, result}, 10'h0);
        for (int p = 0; p < 12; p++) begin
            convert(5'(p), 12'h001 << p, 2'b00, 8'(p * 16 + 7));
        end
        t_no_leg(5'hc);
        t_no_leg(5'h1c);
        pin_analog_enable_reg_1 = 8'hef;
        t_no_leg(5'h4);
        pin_analog_enable_reg_1 = 8'hff;
        convert(CH_REF_HIGH, 12'h000, 2'b10, 8'hff);
        convert(CH_REF_LOW, 12'h000, 2'b01, 8'h00);
        t_clock();
        t_compare();
        sw_write(5'h0);
        tick(3);
        convert(5'hb, 12'h800, 2'b00, 8'hb7);
        t_cont();
        t_hw();
        stop_test();
    end

    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
